/* core/rcs_pkg.sv */
// package: constants of the relay close/open sequencer
// assumes a 25 MHz clock and a 32-bit AXI4-Lite register bus
package rcs_pkg;
   // timing
   localparam int CLK_KHZ    = 25000;
   localparam int SETTLE_NS  = 5000;     // relay settling time per step
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_KHZ + 999999) / 1000000;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_CMD   = 8'h04;
   localparam logic [7:0] OFS_LIST  = 8'h08;
   localparam logic [7:0] OFS_SLOTS = 8'h0C;
   localparam logic [7:0] OFS_ASSOC = 8'h10;
   localparam logic [7:0] OFS_CFG   = 8'h14;
   localparam logic [7:0] OFS_FOUR  = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1C;
   localparam logic [7:0] OFS_STAT  = 8'h20;
   // control fields and reset value
   localparam int CTRL_RULE_LSB  = 0;
   localparam int CTRL_SEQ_BIT   = 2;
   localparam int CTRL_DRV_LSB   = 3;
   localparam int CTRL_MAX_LSB   = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0080;
   // status fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ERR_BIT  = 1;
   localparam int STAT_REF_BIT  = 2;
   // command field
   localparam int CMD_CH_LSB = 8;
   // connect rule codes
   localparam logic [1:0] RULE_BREAK_BEFORE_MAKE = 2'h0;
   localparam logic [1:0] RULE_MAKE_BEFORE_BREAK = 2'h1;
   localparam logic [1:0] RULE_OFF               = 2'h2;
   // drive scheme codes
   localparam logic [1:0] DRV_DIRECT = 2'h0;
   localparam logic [1:0] DRV_MATRIX = 2'h1;
   localparam logic [1:0] DRV_HYBRID = 2'h2;
   // command codes
   localparam logic [2:0] OP_CLOSE    = 3'h0;
   localparam logic [2:0] OP_EXCL     = 3'h1;
   localparam logic [2:0] OP_EXCL_SLT = 3'h2;
   localparam logic [2:0] OP_OPEN     = 3'h3;
   localparam logic [2:0] OP_DMM_CLS  = 3'h4;
   localparam logic [2:0] OP_DMM_OPN  = 3'h5;
   // relay image layout: two slots of 16 relays
   localparam int RELAYS   = 32;
   localparam int SLOTS    = 2;
   localparam int SLOT_W   = 16;
   localparam int BP_IN    = 14;
   localparam int BP_SENSE = 15;
   localparam int PAIR_OFS = 7;
   localparam int CNT_W    = 16;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_SETTLE} rcs_state_t;
endpackage

/* core/rcs_sequencer.sv */
// relay close/open sequencer with an AXI4-Lite register slave
// assumes o_relay drives the relay coils directly, one bit per relay
//
// Added by the designer: the AXI4-Lite slave port and the address map.
module rcs_sequencer #(
   parameter int SETTLE_CYC = rcs_pkg::SETTLE_CYC
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   // axi4-lite write address and data
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   // axi4-lite write response
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // axi4-lite read
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // relay drive and activity
   output logic [31:0]      o_relay,
   output logic             o_busy
);
   // bus-side registers
   logic [31:0] ctrl_r, ctrl_nxt, list_r, list_nxt, assoc_r, assoc_nxt;
   logic [31:0] cfg_r, cfg_nxt, four_r, four_nxt, rdata_r, rdata_nxt;
   logic [1:0]  slots_r, slots_nxt, bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic        err_r, err_nxt, ref_r, ref_nxt;
   // sequencer registers
   rcs_pkg::rcs_state_t state_r, state_nxt;
   logic [31:0] img_r, img_nxt, po_r, po_nxt, pc_r, pc_nxt;
   logic [rcs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   // command decode
   logic        wr_fire, cmd_wr, start, dmm_bad;
   logic [2:0]  op;
   logic [4:0]  ch;
   logic [31:0] lx, dset, tgt, smask, ao, ac, keep;
   logic [5:0]  lim, used;
   logic [1:0]  rule, drv;
   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction
   assign rule = ctrl_r[rcs_pkg::CTRL_RULE_LSB +: 2];
   assign drv  = ctrl_r[rcs_pkg::CTRL_DRV_LSB +: 2];
   assign op   = i_wdata[2:0];
   assign ch   = i_wdata[rcs_pkg::CMD_CH_LSB +: 5];
   assign wr_fire = i_awvalid & i_wvalid & ~bvalid_r;
   assign cmd_wr  = wr_fire & (i_awaddr == rcs_pkg::OFS_CMD) & i_wstrb[0];
   // list expansion and slot masks, one pass per slot
   for (genvar s = 0; s < rcs_pkg::SLOTS; s++) begin : g_slot
      localparam int B = s * rcs_pkg::SLOT_W;
      logic [rcs_pkg::SLOT_W-1:0] sl;
      assign sl = list_r[B +: rcs_pkg::SLOT_W];
      always_comb begin
         lx[B +: rcs_pkg::SLOT_W] = sl;
         // assigned backplane relay joins its channel
         if (|(sl[rcs_pkg::BP_IN-1:0] & assoc_r[B +: rcs_pkg::BP_IN])) begin
            lx[B + rcs_pkg::BP_IN] = 1'b1;
         end
         smask[B +: rcs_pkg::SLOT_W] = {rcs_pkg::SLOT_W{slots_r[s]}};
      end
   end
   // dmm set for the channel named in the command
   always_comb begin
      dset = 32'h0000_0000;
      dset[ch] = 1'b1;
      dset[{ch[4], 4'(rcs_pkg::BP_IN)}] = 1'b1;  // input for both two- and four-pole
      if (four_r[ch]) begin
         dset[ch + 5'(rcs_pkg::PAIR_OFS)] = 1'b1;   // pair gives two poles
         dset[{ch[4], 4'(rcs_pkg::BP_SENSE)}] = 1'b1;
      end
      dmm_bad = ~cfg_r[ch] | (ch[3:0] >= 4'(rcs_pkg::BP_IN))
              | (four_r[ch] & (ch[3:0] >= 4'(rcs_pkg::PAIR_OFS)));
   end
   // target image of the requested command
   always_comb begin
      tgt   = img_r;
      start = cmd_wr & (state_r == rcs_pkg::ST_IDLE);
      case (op)
         rcs_pkg::OP_CLOSE:    tgt = img_r | lx;
         rcs_pkg::OP_EXCL:     tgt = lx;
         rcs_pkg::OP_EXCL_SLT: tgt = (img_r & ~smask) | (lx & smask);
         rcs_pkg::OP_OPEN:     tgt = img_r & ~lx;
         rcs_pkg::OP_DMM_CLS: begin
            tgt = (img_r & ~(ch[4] ? 32'hFFFF_0000 : 32'h0000_FFFF)) | dset;
            start = start & ~dmm_bad;
         end
         rcs_pkg::OP_DMM_OPN: begin
            tgt = img_r & ~dset;
            start = start & ~dmm_bad;
         end
         default: start = 1'b0;
      endcase
   end
   // register bus next values
   always_comb begin
      ctrl_nxt  = ctrl_r;
      list_nxt  = list_r;
      slots_nxt = slots_r;
      assoc_nxt = assoc_r;
      cfg_nxt   = cfg_r;
      four_nxt  = four_r;
      err_nxt   = err_r;
      ref_nxt   = ref_r;
      bvalid_nxt = bvalid_r & ~i_bready;
      bresp_nxt  = bresp_r;
      rvalid_nxt = rvalid_r & ~i_rready;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;
      if (wr_fire) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = rcs_pkg::RESP_OKAY;
         case (i_awaddr)
            rcs_pkg::OFS_CTRL:  ctrl_nxt = merge(ctrl_r, i_wdata, i_wstrb);
            rcs_pkg::OFS_CMD:   ;
            rcs_pkg::OFS_LIST:  list_nxt = merge(list_r, i_wdata, i_wstrb);
            rcs_pkg::OFS_SLOTS: slots_nxt = i_wstrb[0] ? i_wdata[1:0] : slots_r;
            rcs_pkg::OFS_ASSOC: assoc_nxt = merge(assoc_r, i_wdata, i_wstrb);
            rcs_pkg::OFS_CFG:   cfg_nxt = merge(cfg_r, i_wdata, i_wstrb);
            rcs_pkg::OFS_FOUR:  four_nxt = merge(four_r, i_wdata, i_wstrb);
            rcs_pkg::OFS_STATE: ;
            rcs_pkg::OFS_STAT: begin
               // write one clears
               if (i_wstrb[0] & i_wdata[rcs_pkg::STAT_ERR_BIT]) begin
                  err_nxt = 1'b0;
               end
               if (i_wstrb[0] & i_wdata[rcs_pkg::STAT_REF_BIT]) begin
                  ref_nxt = 1'b0;
               end
            end
            default: bresp_nxt = rcs_pkg::RESP_SLVERR;
         endcase
      end
      // hardware set wins over a same-cycle clear
      if (cmd_wr & (state_r != rcs_pkg::ST_IDLE)) begin
         ref_nxt = 1'b1;
      end
      if (cmd_wr & (state_r == rcs_pkg::ST_IDLE) & op[2] & ~op[1] & dmm_bad) begin
         err_nxt = 1'b1;
      end
      if (i_arvalid & ~rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = rcs_pkg::RESP_OKAY;
         case (i_araddr)
            rcs_pkg::OFS_CTRL:  rdata_nxt = ctrl_r;
            rcs_pkg::OFS_CMD:   rdata_nxt = 32'h0000_0000;
            rcs_pkg::OFS_LIST:  rdata_nxt = list_r;
            rcs_pkg::OFS_SLOTS: rdata_nxt = {30'h0000_0000, slots_r};
            rcs_pkg::OFS_ASSOC: rdata_nxt = assoc_r;
            rcs_pkg::OFS_CFG:   rdata_nxt = cfg_r;
            rcs_pkg::OFS_FOUR:  rdata_nxt = four_r;
            rcs_pkg::OFS_STATE: rdata_nxt = img_r;
            rcs_pkg::OFS_STAT:  rdata_nxt = {29'h0000_0000, ref_r, err_r, o_busy};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = rcs_pkg::RESP_SLVERR;
            end
         endcase
      end
   end
   // register bus flip-flops
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ctrl_r   <= rcs_pkg::CTRL_RESET;  // break-first, sequential off
         list_r   <= 32'h0000_0000;
         slots_r  <= 2'h0;
         assoc_r  <= 32'h0000_0000;
         cfg_r    <= 32'h0000_0000;
         four_r   <= 32'h0000_0000;
         err_r    <= 1'b0;
         ref_r    <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r  <= rcs_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r  <= rcs_pkg::RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end else begin
         ctrl_r   <= ctrl_nxt;
         list_r   <= list_nxt;
         slots_r  <= slots_nxt;
         assoc_r  <= assoc_nxt;
         cfg_r    <= cfg_nxt;
         four_r   <= four_nxt;
         err_r    <= err_nxt;
         ref_r    <= ref_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r  <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r  <= rresp_nxt;
         rdata_r  <= rdata_nxt;
      end
   end
   // choice of relays for the next step
   always_comb begin
      ao = 32'h0000_0000;
      ac = 32'h0000_0000;
      case (rule)
         rcs_pkg::RULE_MAKE_BEFORE_BREAK: begin
            if (|pc_r) begin
               ac = pc_r;  // closes settle first
            end else begin
               ao = po_r;
            end
         end
         rcs_pkg::RULE_OFF: begin
            ao = po_r;  // no ordering
            ac = pc_r;
         end
         default: begin
            if (|po_r) begin
               ao = po_r;  // opens settle first
            end else begin
               ac = pc_r;
            end
         end
      endcase
      if (ctrl_r[rcs_pkg::CTRL_SEQ_BIT]) begin
         lim = 6'h01;  // one relay a step
      end else if (drv == rcs_pkg::DRV_MATRIX) begin
         lim = (ctrl_r[rcs_pkg::CTRL_MAX_LSB +: 5] == 5'h00) ? 6'h01
             : {1'b0, ctrl_r[rcs_pkg::CTRL_MAX_LSB +: 5]};
      end else begin
         lim = 6'(rcs_pkg::RELAYS);  // all together
      end
      keep = 32'h0000_0000;
      used = 6'h00;
      for (int i = 0; i < rcs_pkg::RELAYS; i++) begin
         if ((ao[i] | ac[i]) && (used < lim)) begin
            keep[i] = 1'b1;
            used = used + 6'h01;
         end
      end
   end
   // sequencer next values
   always_comb begin
      state_nxt = state_r;
      img_nxt   = img_r;
      po_nxt    = po_r;
      pc_nxt    = pc_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         rcs_pkg::ST_IDLE: begin
            if (start) begin
               po_nxt = img_r & ~tgt;
               pc_nxt = tgt & ~img_r;  // closed and wanted stays
               if (|(img_r ^ tgt)) begin
                  state_nxt = rcs_pkg::ST_STEP;
               end
            end
         end
         rcs_pkg::ST_STEP: begin
            img_nxt = (img_r | (ac & keep)) & ~(ao & keep);
            po_nxt  = po_r & ~keep;
            pc_nxt  = pc_r & ~keep;
            cnt_nxt = rcs_pkg::CNT_W'(SETTLE_CYC - 1);
            state_nxt = rcs_pkg::ST_SETTLE;
         end
         rcs_pkg::ST_SETTLE: begin
            if (cnt_r == '0) begin
               state_nxt = (|(po_r | pc_r)) ? rcs_pkg::ST_STEP : rcs_pkg::ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: state_nxt = rcs_pkg::ST_IDLE;
      endcase
   end
   // sequencer flip-flops
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_r <= rcs_pkg::ST_IDLE;
         img_r   <= 32'h0000_0000;  // all relays open
         po_r    <= 32'h0000_0000;
         pc_r    <= 32'h0000_0000;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         img_r   <= img_nxt;
         po_r    <= po_nxt;
         pc_r    <= pc_nxt;
         cnt_r   <= cnt_nxt;
      end
   end
   // outputs
   assign o_awready = wr_fire;
   assign o_wready  = wr_fire;
   assign o_bvalid  = bvalid_r;
   assign o_bresp   = bresp_r;
   assign o_arready = ~rvalid_r;
   assign o_rvalid  = rvalid_r;
   assign o_rdata   = rdata_r;
   assign o_rresp   = rresp_r;
   assign o_relay   = img_r;
   assign o_busy    = (state_r != rcs_pkg::ST_IDLE);
endmodule

/* testbench/rcs_relay_model.sv */
// model: relay coil drivers on the switching modules
// assumes one coil bit per relay, contacts follow a cycle later
module rcs_relay_model (
   // clock and peak clear
   input wire logic        i_clock,
   input wire logic        i_clear,
   // coil drive
   input wire logic [31:0] i_coil,
   // contacts and most relays switched at once
   output logic [31:0]     o_contact,
   output int              o_peak
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_contact = 32'h0;
      o_peak = 0;
   end
   // contacts follow coils, peak drive load tracked
   always @(posedge i_clock) begin
      o_contact <= i_coil;
      if (i_clear) o_peak <= 0;
      else if ($countones(i_coil ^ o_contact) > o_peak) o_peak <= $countones(i_coil ^ o_contact);
   end
endmodule

/* testbench/rcs_sequencer_sva.sv */
// checker: port properties of the relay sequencer
// assumes binding onto rcs_sequencer, single clock domain
module rcs_sequencer_sva #(
   parameter int SETTLE_CYC = rcs_pkg::SETTLE_CYC
) (
   // clock and reset
   input wire logic        i_clock,
   input wire logic        i_srst,
   // register bus
   input wire logic [7:0]  i_awaddr,
   input wire logic        i_awvalid,
   input wire logic        o_awready,
   input wire logic        o_bvalid,
   input wire logic [7:0]  i_araddr,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic        o_rvalid,
   // relays
   input wire logic [31:0] o_relay,
   input wire logic        o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BUSY_MAX = (SETTLE_CYC + 1) * rcs_pkg::RELAYS + 4;
   logic [31:0] prev_r;
   logic [15:0] since_r, since_nxt, busy_r, busy_nxt;
   // cycles since last relay change, length of busy
   always_comb begin
      since_nxt = (since_r == 16'hFFFF) ? since_r : since_r + 16'h1;
      if (o_relay != prev_r) since_nxt = 16'h0;
      busy_nxt = o_busy ? busy_r + 16'h1 : 16'h0;
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         prev_r  <= 32'h0;
         since_r <= 16'hFFFF;
         busy_r  <= 16'h0;
      end else begin
         prev_r  <= o_relay;
         since_r <= since_nxt;
         busy_r  <= busy_nxt;
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   property p_open_reset;  $fell(i_srst) |-> o_relay == 32'h0; endproperty
   property p_quiet_idle;  o_relay != prev_r |-> o_busy; endproperty
   property p_settle;      o_relay != prev_r |-> since_r >= 16'(SETTLE_CYC); endproperty
   property p_first_step;  $rose(o_busy) |=> o_relay != prev_r; endproperty
   property p_cmd_start;
      $rose(o_busy) |-> $past(i_awvalid && o_awready && i_awaddr == rcs_pkg::OFS_CMD);
   endproperty
   property p_busy_bound;  busy_r < 16'(BUSY_MAX); endproperty
   property p_bresp;       i_awvalid && o_awready |=> o_bvalid; endproperty
   property p_bblock;      o_bvalid |-> !o_awready; endproperty
   property p_rresp;       i_arvalid && o_arready |=> o_rvalid ##0 !o_arready; endproperty
   property p_state_read;
      i_arvalid && o_arready && i_araddr == rcs_pkg::OFS_STATE |=> o_rdata == $past(o_relay);
   endproperty
   a_open_reset: assert property (p_open_reset)
      else $error("relays not open after reset");
   a_quiet_idle: assert property (p_quiet_idle)
      else $error("relay changed while idle");
   a_settle: assert property (p_settle)
      else $error("relay step before settling");
   a_first_step: assert property (p_first_step)
      else $error("no relay step after start");
   a_cmd_start: assert property (p_cmd_start)
      else $error("busy without command write");
   a_busy_bound: assert property (p_busy_bound)
      else $error("command runs too long");
   a_bresp: assert property (p_bresp)
      else $error("write response missing");
   a_bblock: assert property (p_bblock)
      else $error("write taken during response");
   a_rresp: assert property (p_rresp)
      else $error("read response missing");
   a_state_read: assert property (p_state_read)
      else $error("state read differs from relays");
   c_start: cover property ($rose(o_busy));
   c_step: cover property (o_relay != prev_r && since_r == 16'(SETTLE_CYC));
   c_state: cover property (i_arvalid && o_arready && i_araddr == rcs_pkg::OFS_STATE);
endmodule

bind rcs_sequencer rcs_sequencer_sva #(.SETTLE_CYC(SETTLE_CYC)) u_sva (
   .i_clock(i_clock), .i_srst(i_srst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .o_bvalid(o_bvalid), .i_araddr(i_araddr),
   .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
   .o_rvalid(o_rvalid), .o_relay(o_relay), .o_busy(o_busy)
);

/* testbench/tb_relay_close_open_sequencer.sv */
// testbench: command sequences over the register bus with expected relay images
// assumes rcs_sequencer with a short settle count and the relay model
module tb_relay_close_open_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SETTLE = 3;
   // bench signals
   logic        i_clock = 1'b0;
   logic        i_srst  = 1'b1;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        clr     = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, busy;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, relay, contact, first_img, kept, rd;
   int          peak, steps, cycles = 0, miscompares = 0, checks_done = 0;
   // design and relay drivers
   rcs_sequencer #(.SETTLE_CYC(SETTLE)) dut (
      .i_clock(i_clock), .i_srst(i_srst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_relay(relay), .o_busy(busy)
   );
   rcs_relay_model model_u (
      .i_clock(i_clock), .i_clear(clr), .i_coil(relay), .o_contact(contact), .o_peak(peak)
   );
   // clock
   always #20 i_clock = ~i_clock;
   // step tracking per command, run limit
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (clr && !busy) begin
         steps <= 0;
         kept  <= 32'hFFFF_FFFF;
      end else begin
         kept <= kept & relay;
         if (relay !== contact) begin
            if (steps == 0) first_img <= relay;
            steps <= steps + 1;
         end
      end
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      clr <= 1'b1;
      do @(negedge i_clock); while (awready !== 1'b1 || wready !== 1'b1);
      @(posedge i_clock);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      clr <= 1'b0;
      do @(negedge i_clock); while (bvalid !== 1'b1);
      rsp = bresp;
      @(posedge i_clock);
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge i_clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge i_clock); while (arready !== 1'b1);
      @(posedge i_clock);
      arvalid <= 1'b0;
      do @(negedge i_clock); while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      @(posedge i_clock);
      rready <= 1'b0;
   endtask
   task automatic go(input logic [31:0] list, input logic [2:0] op, input logic [4:0] ch);
      wr(rcs_pkg::OFS_LIST, list);
      wr(rcs_pkg::OFS_CMD, {19'h0, ch, 5'h0, op});
   endtask
   task automatic idle;
      do @(negedge i_clock); while (busy !== 1'b0);
   endtask
   task automatic cmd(input logic [31:0] list, input logic [2:0] op, input logic [4:0] ch);
      go(list, op, ch);
      idle();
   endtask
   task automatic st(input logic [31:0] exp);
      rd_reg(rcs_pkg::OFS_STATE);
      chk(exp, rd, "relay state");
   endtask
   task automatic results;
      if (miscompares == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge i_clock);
      i_srst <= 1'b0;
      rd_reg(rcs_pkg::OFS_CTRL);
      chk(32'h0000_0080, rd, "ctrl reset");
      st(32'h0);
      rd_reg(8'h40);
      chk({30'h0, rcs_pkg::RESP_SLVERR}, {30'h0, rsp}, "unmapped resp");
      wr(8'h40, 32'h0);
      chk({30'h0, rcs_pkg::RESP_SLVERR}, {30'h0, rsp}, "unmapped write resp");
      wr(rcs_pkg::OFS_ASSOC, 32'h0000_0002);
      wr(rcs_pkg::OFS_CFG, 32'h0000_0005);
      wr(rcs_pkg::OFS_FOUR, 32'h0000_0001);
      wr(rcs_pkg::OFS_CTRL, 32'h0000_0082);
      cmd(32'h1, rcs_pkg::OP_EXCL, 5'h0);
      st(32'h1);
      chk(32'h1, steps, "steps");
      cmd(32'h2, rcs_pkg::OP_EXCL, 5'h0);
      st(32'h4002);
      cmd(32'h0, rcs_pkg::OP_DMM_CLS, 5'h0);
      st(32'hC081);
      chk(32'h4000, kept & 32'h4000, "input relay held");
      cmd(32'h0, rcs_pkg::OP_DMM_CLS, 5'h2);
      st(32'h4004);
      chk(32'h4000, kept & 32'h4000, "input relay held");
      cmd(32'h0, rcs_pkg::OP_DMM_CLS, 5'h3);
      st(32'h4004);
      rd_reg(rcs_pkg::OFS_STAT);
      chk(32'h2, rd, "status");
      wr(rcs_pkg::OFS_STAT, 32'h2);
      cmd(32'h0, rcs_pkg::OP_DMM_OPN, 5'h2);
      st(32'h0);
      cmd(32'h1_0000, rcs_pkg::OP_CLOSE, 5'h0);
      wr(rcs_pkg::OFS_SLOTS, 32'h1);
      cmd(32'h20, rcs_pkg::OP_EXCL_SLT, 5'h0);
      st(32'h1_0020);
      cmd(32'h1_0000, rcs_pkg::OP_OPEN, 5'h0);
      st(32'h20);
      wr(rcs_pkg::OFS_CTRL, 32'h80);
      cmd(32'h40, rcs_pkg::OP_EXCL, 5'h0);
      chk(32'h2, steps, "steps");
      chk(32'h0, first_img, "first step");
      wr(rcs_pkg::OFS_CTRL, 32'h81);
      go(32'h20, rcs_pkg::OP_EXCL, 5'h0);
      wr(rcs_pkg::OFS_CMD, {29'h0, rcs_pkg::OP_OPEN});
      rd_reg(rcs_pkg::OFS_STAT);
      chk(32'h5, rd, "status busy");
      idle();
      st(32'h20);
      chk(32'h60, first_img, "first step");
      rd_reg(rcs_pkg::OFS_STAT);
      chk(32'h4, rd, "status");
      wr(rcs_pkg::OFS_CTRL, 32'h86);
      cmd(32'h7, rcs_pkg::OP_EXCL, 5'h0);
      st(32'h4007);
      chk(32'h5, steps, "steps");
      wr(rcs_pkg::OFS_CTRL, 32'h4A);
      cmd(32'h0, rcs_pkg::OP_EXCL, 5'h0);
      chk(32'h2, steps, "steps");
      chk(32'h2, peak, "peak drive");
      wr(rcs_pkg::OFS_CTRL, 32'h90);
      cmd(32'h7F, rcs_pkg::OP_CLOSE, 5'h0);
      cmd(32'h100, rcs_pkg::OP_EXCL, 5'h0);
      st(32'h100);
      chk(32'h2, steps, "steps");
      results();
   end
endmodule
